/* File: ufx_host_model.sv */
// Behavioural host-side partner that drives bus power, line levels and tokens.
`timescale 1ns/1ps
module ufx_host_model
   import ufx_pkg::*;
(
   input wire logic clk_in,
   output logic vbus_out,
   output logic dp_out,
   output logic dn_out,
   output ufx_token_t token_out
);
   // ------------------------------------------------------------
   // Idle bus
   // ------------------------------------------------------------
   // Starts unpowered, in the full speed idle line state, with no token.
   initial
   begin
      vbus_out = 1'b0;
      dp_out = 1'b1;
      dn_out = 1'b0;
      token_out = '0;
   end

   // Power and line levels change just after a rising edge.
   task automatic set_bus(input logic v, input logic p, input logic n);
      @(posedge clk_in);
      vbus_out <= v;
      dp_out <= p;
      dn_out <= n;
   endtask

   // A token or frame start stands for one cycle; the host only issues, never answers.
   task automatic send(input logic sof, input logic [7:0] addr);
      @(posedge clk_in);
      token_out <= '{valid: ~sof, sof: sof, addr: addr};
      @(posedge clk_in);
      token_out <= '{valid: 1'b0, sof: 1'b0, addr: ~addr};
   endtask
endmodule // ufx_host_model

/* File: ufx_pkg.sv */
// Package of constants and types for the USB function transceiver and endpoint block.
package ufx_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ---------------------------------------------------------------
   localparam int UFX_AW = 5;
   localparam logic [4:0] OFS_XCTL = 5'h00;
   localparam logic [4:0] OFS_BADR = 5'h04;
   localparam logic [4:0] OFS_BDAT = 5'h08;
   localparam logic [4:0] OFS_PIPE = 5'h0C;
   localparam logic [4:0] OFS_TRIM = 5'h10;

   // Transceiver control field positions and reset value.
   localparam int XC_PULLUP_ENABLE = 7;
   localparam int XC_XEN = 6;
   localparam int XC_SPEED = 5;
   localparam int XC_TST_HI = 4;
   localparam int XC_TST_LO = 3;
   localparam int XC_DIFFERENTIAL_RECEIVE_STATE = 2;
   localparam int XC_DP = 1;
   localparam int XC_DN = 0;
   localparam logic [7:0] XCTL_RST = 8'h00;

   // Buffer memory and pipe layout.
   localparam int BUF_BYTES = 256;
   localparam logic [7:0] EP1_IN_BASE = 8'h00;
   localparam logic [7:0] EP1_OUT_BASE = 8'h40;
   localparam logic [7:0] EP0_BASE = 8'hC0;
   localparam logic [7:0] PADDR_EP0 = 8'h00;
   localparam logic [7:0] PADDR_EP1_IN = 8'h81;
   localparam logic [7:0] PADDR_EP1_OUT = 8'h01;

   // Clock recovery timing.
   localparam int FRAME_NS = 1000000;
   localparam int CLK_NS = 100;
   localparam int FRAME_CYC = FRAME_NS / CLK_NS;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam logic [7:0] TRIM_MAX = 8'hFF;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PIPE_EP0, PIPE_EP1_IN, PIPE_EP1_OUT, PIPE_NONE} ufx_pipe_t;

   // Token strobe from the serial interface engine.
   typedef struct packed {
      logic valid;
      logic sof;
      logic [7:0] addr;
   } ufx_token_t;

   // Whole state of the block except the buffer memory.
   typedef struct packed {
      logic vbus_m, vbus_s, dp_m, dp_s, dn_m, dn_s;
      logic pullup_enable, xen, speed;
      logic [1:0] tst;
      logic awrdy, wrdy, aw_got, w_got, bvalid, wstb;
      logic [1:0] bresp;
      logic [2:0] awidx;
      logic [7:0] wdata;
      logic arrdy, rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] bptr;
      logic pu_dp, pu_dn, hit;
      ufx_pipe_t pipe;
      logic [7:0] base;
      logic [15:0] fcnt;
      logic [7:0] trim;
   } ufx_state_t;

endpackage

/* File: ufx_top.sv */
// USB function front end: transceiver control, pipe decode, buffer memory, clock recovery.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module ufx_top
   import ufx_pkg::*;
#(
   parameter int FRAME_CYCLES = FRAME_CYC
)
(
   input wire logic MCLK_IN,
   input wire logic RST_B_IN,
   input wire logic AWVALID_IN,
   output logic AWREADY_OUT,
   input wire logic [UFX_AW-1:0] AWADDR_IN,
   input wire logic WVALID_IN,
   output logic WREADY_OUT,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   output logic BVALID_OUT,
   input wire logic BREADY_IN,
   output logic [1:0] BRESP_OUT,
   input wire logic ARVALID_IN,
   output logic ARREADY_OUT,
   input wire logic [UFX_AW-1:0] ARADDR_IN,
   output logic RVALID_OUT,
   input wire logic RREADY_IN,
   output logic [31:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   input wire logic VBUS_IN,
   input wire logic LINE_DP_IN,
   input wire logic LINE_DN_IN,
   input wire ufx_token_t TOKEN_IN,
   output logic XCVR_EN_OUT,
   output logic FULL_SPEED_OUT,
   output logic PULLUP_DP_OUT,
   output logic PULLUP_DN_OUT,
   output logic [1:0] TEST_MODE_OUT,
   output logic PIPE_HIT_OUT,
   output ufx_pipe_t PIPE_SEL_OUT,
   output logic [7:0] PIPE_BASE_OUT,
   output logic [7:0] CLK_TRIM_OUT
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------

   ufx_state_t st_reg;
   ufx_state_t st_next;
   logic [7:0] buf_mem [BUF_BYTES];
   logic mem_we;
   logic [7:0] mem_wa;
   logic [7:0] mem_wd;
   logic [7:0] rd;
   logic [7:0] xctl_view;

   // Control register as software sees it, line states in the low bits.
   assign xctl_view = {st_reg.pullup_enable, st_reg.xen, st_reg.speed, st_reg.tst,
                       st_reg.dp_s & ~st_reg.dn_s, st_reg.dp_s, st_reg.dn_s};

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------

   // Computes the whole next state; the block only answers the host, it never issues tokens.
   always_comb
   begin
      st_next = st_reg;
      mem_we = 1'b0;
      mem_wa = st_reg.bptr;
      mem_wd = st_reg.wdata;
      rd = 8'h00;

      // Bus power and line pins pass two flip-flops before use.
      st_next.vbus_m = VBUS_IN;
      st_next.vbus_s = st_reg.vbus_m;
      st_next.dp_m = LINE_DP_IN;
      st_next.dp_s = st_reg.dp_m;
      st_next.dn_m = LINE_DN_IN;
      st_next.dn_s = st_reg.dn_m;

      // Write address and data are taken in either order.
      if (AWVALID_IN && st_reg.awrdy)
      begin
         st_next.aw_got = 1'b1;
         st_next.awidx = AWADDR_IN[4:2];
      end
      if (WVALID_IN && st_reg.wrdy)
      begin
         st_next.w_got = 1'b1;
         st_next.wdata = WDATA_IN[7:0];
         st_next.wstb = WSTRB_IN[0];
      end
      if (BREADY_IN && st_reg.bvalid)
      begin
         st_next.bvalid = 1'b0;
      end

      // Performs the write once both halves are held and no response waits.
      if (st_next.aw_got && st_next.w_got && !st_next.bvalid)
      begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         case (st_next.awidx)
            OFS_XCTL[4:2]:
            begin
               if (st_next.wstb)
               begin
                  st_next.pullup_enable = st_next.wdata[XC_PULLUP_ENABLE];
                  st_next.xen = st_next.wdata[XC_XEN];
                  st_next.speed = st_next.wdata[XC_SPEED];
                  st_next.tst = st_next.wdata[XC_TST_HI:XC_TST_LO];
               end
            end
            OFS_BADR[4:2]:
            begin
               if (st_next.wstb)
               begin
                  st_next.bptr = st_next.wdata;
               end
            end
            OFS_BDAT[4:2]:
            begin
               // Buffer byte write, pointer steps on.
               if (st_next.wstb)
               begin
                  mem_we = 1'b1;
                  mem_wa = st_reg.bptr;
                  mem_wd = st_next.wdata;
                  st_next.bptr = st_reg.bptr + 8'h01;
               end
            end
            OFS_PIPE[4:2]:
            begin
               st_next.bresp = RESP_OKAY;
            end
            OFS_TRIM[4:2]:
            begin
               if (st_next.wstb)
               begin
                  st_next.trim = st_next.wdata;
               end
            end
            default:
            begin
               st_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      st_next.awrdy = !st_next.aw_got && !st_next.bvalid;
      st_next.wrdy = !st_next.w_got && !st_next.bvalid;

      // Read channel: one read under way at a time.
      if (RREADY_IN && st_reg.rvalid)
      begin
         st_next.rvalid = 1'b0;
      end
      if (ARVALID_IN && st_reg.arrdy)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp = RESP_OKAY;
         case (ARADDR_IN[4:2])
            OFS_XCTL[4:2]:
            begin
               rd = xctl_view;
            end
            OFS_BADR[4:2]:
            begin
               rd = st_next.bptr;
            end
            OFS_BDAT[4:2]:
            begin
               rd = buf_mem[st_next.bptr];
               st_next.bptr = st_next.bptr + 8'h01;
            end
            OFS_PIPE[4:2]:
            begin
               rd = {st_reg.vbus_s, st_reg.hit, 4'h0, st_reg.pipe};
            end
            OFS_TRIM[4:2]:
            begin
               rd = st_reg.trim;
            end
            default:
            begin
               st_next.rresp = RESP_SLVERR;
            end
         endcase
         st_next.rdata = rd;
      end
      st_next.arrdy = !st_next.rvalid;

      // Pullup lands on D+ at full speed, D- at low speed, only with bus power.
      st_next.pu_dp = st_reg.pullup_enable & st_reg.vbus_s & st_reg.speed;
      st_next.pu_dn = st_reg.pullup_enable & st_reg.vbus_s & ~st_reg.speed;

      // Maps a token's protocol address onto one of the three pipes.
      st_next.hit = 1'b0;
      if (TOKEN_IN.valid && st_reg.xen)
      begin
         case (TOKEN_IN.addr)
            PADDR_EP0:
            begin
               st_next.pipe = PIPE_EP0;
               st_next.base = EP0_BASE;
               st_next.hit = 1'b1;
            end
            PADDR_EP1_IN:
            begin
               st_next.pipe = PIPE_EP1_IN;
               st_next.base = EP1_IN_BASE;
               st_next.hit = 1'b1;
            end
            PADDR_EP1_OUT:
            begin
               st_next.pipe = PIPE_EP1_OUT;
               st_next.base = EP1_OUT_BASE;
               st_next.hit = 1'b1;
            end
            default:
            begin
               st_next.pipe = PIPE_NONE;
            end
         endcase
      end

      // Frame timer: each start-of-frame seen while the transceiver is enabled nudges the trim toward nominal length.
      if (st_reg.fcnt != 16'hFFFF)
      begin
         st_next.fcnt = st_reg.fcnt + 16'h0001;
      end
      if (TOKEN_IN.sof && st_reg.xen)
      begin
         st_next.fcnt = 16'h0000;
         if (st_reg.fcnt < 16'(FRAME_CYCLES - 1) && st_reg.trim != TRIM_MAX)
         begin
            st_next.trim = st_reg.trim + 8'h01;
         end
         else if (st_reg.fcnt > 16'(FRAME_CYCLES - 1) && st_reg.trim != 8'h00)
         begin
            st_next.trim = st_reg.trim - 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------

   // Registers the state; reset clears every control bit, sets the pipe to PIPE_NONE and the trim to TRIM_RST.
   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_B_IN)
      begin
         st_reg <= '0;
         st_reg.pipe <= PIPE_NONE;
         st_reg.trim <= TRIM_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Buffer memory write port.
   always_ff @(posedge MCLK_IN)
   begin
      if (mem_we)
      begin
         buf_mem[mem_wa] <= mem_wd;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------

   // Every output is a state flip-flop, except bits 31 to 8 of RDATA_OUT, which are tied to zero.
   assign AWREADY_OUT = st_reg.awrdy;
   assign WREADY_OUT = st_reg.wrdy;
   assign BVALID_OUT = st_reg.bvalid;
   assign BRESP_OUT = st_reg.bresp;
   assign ARREADY_OUT = st_reg.arrdy;
   assign RVALID_OUT = st_reg.rvalid;
   assign RDATA_OUT = {24'h00_0000, st_reg.rdata};
   assign RRESP_OUT = st_reg.rresp;
   assign XCVR_EN_OUT = st_reg.xen;
   assign FULL_SPEED_OUT = st_reg.speed;
   assign PULLUP_DP_OUT = st_reg.pu_dp;
   assign PULLUP_DN_OUT = st_reg.pu_dn;
   assign TEST_MODE_OUT = st_reg.tst;
   assign PIPE_HIT_OUT = st_reg.hit;
   assign PIPE_SEL_OUT = st_reg.pipe;
   assign PIPE_BASE_OUT = st_reg.base;
   assign CLK_TRIM_OUT = st_reg.trim;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   pullup_dp_a: assert property (st_reg.pullup_enable && st_reg.speed && st_reg.vbus_s
      |=> PULLUP_DP_OUT && !PULLUP_DN_OUT)
      else $error("Pullup not on D+ at full speed.");

   pullup_dn_a: assert property (st_reg.pullup_enable && !st_reg.speed && st_reg.vbus_s
      |=> PULLUP_DN_OUT && !PULLUP_DP_OUT)
      else $error("Pullup not on D- at low speed.");

   pullup_vbus_a: assert property (!VBUS_IN [*4] |-> !PULLUP_DP_OUT && !PULLUP_DN_OUT)
      else $error("Pullup on without bus power.");

   ep_zero_a: assert property (TOKEN_IN.valid && XCVR_EN_OUT && TOKEN_IN.addr == PADDR_EP0
      |=> PIPE_HIT_OUT && PIPE_SEL_OUT == PIPE_EP0 && PIPE_BASE_OUT == EP0_BASE)
      else $error("Endpoint zero token not mapped.");

   ep_one_a: assert property (TOKEN_IN.valid && XCVR_EN_OUT && TOKEN_IN.addr == PADDR_EP1_IN
      |=> PIPE_HIT_OUT && PIPE_SEL_OUT == PIPE_EP1_IN && PIPE_BASE_OUT == EP1_IN_BASE)
      else $error("Endpoint one IN token not mapped.");

   pipe_count_a: assert property (PIPE_HIT_OUT |-> PIPE_SEL_OUT != PIPE_NONE
      && $past(TOKEN_IN.valid))
      else $error("Pipe hit without a known pipe.");

   line_read_a: assert property (ARVALID_IN && ARREADY_OUT && ARADDR_IN[4:2] == OFS_XCTL[4:2]
      |=> RVALID_OUT && RDATA_OUT[1:0] == $past({st_reg.dp_s, st_reg.dn_s})
      && RDATA_OUT[7:3] == $past({st_reg.pullup_enable, st_reg.xen, st_reg.speed, st_reg.tst}))
      else $error("Control register read is wrong.");

   reset_clear_a: assert property ($past(!RST_B_IN) |-> !XCVR_EN_OUT && !FULL_SPEED_OUT
      && TEST_MODE_OUT == 2'h0 && !PULLUP_DP_OUT && !PULLUP_DN_OUT)
      else $error("Control bits not clear after reset.");

   trim_up_a: assert property (TOKEN_IN.sof && XCVR_EN_OUT && st_reg.trim != TRIM_MAX
      && st_reg.fcnt < 16'(FRAME_CYCLES - 1) |=> CLK_TRIM_OUT == $past(CLK_TRIM_OUT) + 8'h01)
      else $error("Short frame did not raise trim.");

endmodule // ufx_top

/* File: ufx_top_tb.sv */
// Self-checking testbench of the USB function front end.
`timescale 1ns/1ps
module ufx_top_tb
   import ufx_pkg::*;
;
   localparam int FRAME_T = 50;
   logic mclk = 1'b0;
   logic rst_b, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdat;
   logic [3:0] wstrb;
   logic awrdy, wrdy, bvalid, arrdy, rvalid, xen, fs, pu_dp, pu_dn, hit, vbus, dp, dn;
   logic [1:0] bresp, rresp, tmode, r;
   logic [7:0] base, trim, b;
   logic [31:0] rdata;
   ufx_pipe_t sel;
   ufx_token_t tok;
   int num_errors = 0;
   int checks = 0;

   // Clock of 100 ns period.
   always #50 mclk = ~mclk;

   ufx_host_model host (.clk_in(mclk), .vbus_out(vbus), .dp_out(dp), .dn_out(dn), .token_out(tok));

   ufx_top #(.FRAME_CYCLES(FRAME_T)) dut (.MCLK_IN(mclk), .RST_B_IN(rst_b), .AWVALID_IN(awvalid),
      .AWREADY_OUT(awrdy), .AWADDR_IN(awaddr), .WVALID_IN(wvalid), .WREADY_OUT(wrdy), .WDATA_IN(wdata),
      .WSTRB_IN(wstrb), .BVALID_OUT(bvalid), .BREADY_IN(bready), .BRESP_OUT(bresp), .ARVALID_IN(arvalid),
      .ARREADY_OUT(arrdy), .ARADDR_IN(araddr), .RVALID_OUT(rvalid), .RREADY_IN(rready), .RDATA_OUT(rdata),
      .RRESP_OUT(rresp), .VBUS_IN(vbus), .LINE_DP_IN(dp), .LINE_DN_IN(dn), .TOKEN_IN(tok),
      .XCVR_EN_OUT(xen), .FULL_SPEED_OUT(fs), .PULLUP_DP_OUT(pu_dp), .PULLUP_DN_OUT(pu_dn),
      .TEST_MODE_OUT(tmode), .PIPE_HIT_OUT(hit), .PIPE_SEL_OUT(sel), .PIPE_BASE_OUT(base),
      .CLK_TRIM_OUT(trim));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   // Reports the verdict and ends the run.
   task automatic stop_test();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Writes one register word, waiting for the response under a bound.
   task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      resp = 2'h3;
      @(posedge mclk);
      {awvalid, wvalid, bready} <= 3'h7;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= 4'h1;
      while (n < 100)
      begin
         @(posedge mclk);
         n++;
         if (awvalid && awrdy === 1'b1) awvalid <= 1'b0;
         if (wvalid && wrdy === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            resp = bresp;
            n = 1000;
         end
      end
      bready <= 1'b0;
      if (n != 1000) check("write wait", 32'h0000_0000, 32'h0000_0001);
   endtask

   // Reads one register word, waiting for the data under a bound.
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      resp = 2'h3;
      @(posedge mclk);
      {arvalid, rready} <= 2'h3;
      araddr <= a;
      while (n < 100)
      begin
         @(posedge mclk);
         n++;
         if (arvalid && arrdy === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata;
            resp = rresp;
            n = 1000;
         end
      end
      rready <= 1'b0;
      if (n != 1000) check("read wait", 32'h0000_0000, 32'h0000_0001);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset values, and a token ignored while the transceiver is off.
   task automatic t_reset();
      rd(OFS_XCTL, rdat, r);
      check("xctl reset", rdat, 32'h0000_0006);
      host.send(1'b0, PADDR_EP1_IN);
      @(negedge mclk);
      check("outs reset", {xen, fs, pu_dp, pu_dn, tmode, hit, sel}, {7'h00, PIPE_NONE});
      check("trim reset", trim, TRIM_RST);
   endtask

   // Writable fields follow the write; line states stay read only.
   task automatic t_regs();
      wr(OFS_XCTL, 8'hFF, r);
      @(negedge mclk);
      check("ctl outs", {xen, fs, tmode}, 32'h0000_000F);
      rd(OFS_XCTL, rdat, r);
      check("xctl rw", rdat, 32'h0000_00FE);
      host.set_bus(1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge mclk);
      rd(OFS_XCTL, rdat, r);
      check("xctl lines", rdat, 32'h0000_00F9);
   endtask

   // Pullup placement by speed, gated by bus power.
   task automatic t_pullup();
      @(negedge mclk);
      check("pu no power", {pu_dp, pu_dn}, 32'h0000_0000);
      host.set_bus(1'b1, 1'b1, 1'b0);
      repeat (5) @(posedge mclk);
      check("pu full", {fs, pu_dp, pu_dn}, 32'h0000_0006);
      wr(OFS_XCTL, 8'hC0, r);
      repeat (3) @(posedge mclk);
      check("pu low", {fs, pu_dp, pu_dn}, 32'h0000_0001);
      host.set_bus(1'b0, 1'b1, 1'b0);
      repeat (5) @(posedge mclk);
      check("pu power off", {pu_dp, pu_dn}, 32'h0000_0000);
      wr(OFS_XCTL, 8'h60, r);
   endtask

   // Each protocol address selects its pipe; others miss.
   task automatic t_tokens();
      logic [7:0] ad [5] = '{PADDR_EP0, PADDR_EP1_IN, PADDR_EP1_OUT, 8'h02, 8'h82};
      ufx_pipe_t ps [5] = '{PIPE_EP0, PIPE_EP1_IN, PIPE_EP1_OUT, PIPE_NONE, PIPE_NONE};
      logic [7:0] bs [3] = '{EP0_BASE, EP1_IN_BASE, EP1_OUT_BASE};
      for (int i = 0; i < 5; i++)
      begin
         host.send(1'b0, ad[i]);
         @(negedge mclk);
         check("pipe hit", hit, (i < 3));
         check("pipe sel", sel, ps[i]);
         if (i < 3) check("pipe base", base, bs[i]);
      end
   endtask

   // Buffer memory holds all 256 bytes and its pointer wraps.
   task automatic t_buffer();
      wr(OFS_BADR, 8'h00, r);
      for (int i = 0; i < BUF_BYTES; i++) wr(OFS_BDAT, 8'(i) ^ 8'hA5, r);
      wr(OFS_BADR, 8'h00, r);
      for (int i = 0; i < BUF_BYTES; i++)
      begin
         rd(OFS_BDAT, rdat, r);
         check("buf data", rdat, {24'h00_0000, 8'(i) ^ 8'hA5});
      end
      rd(OFS_BADR, rdat, r);
      check("buf wrap", rdat, 32'h0000_0000);
   endtask

   // Unmapped places answer with an error and read as zero.
   task automatic t_unmapped();
      wr(5'h14, 8'h11, r);
      check("unmapped wr", r, RESP_SLVERR);
      rd(5'h1C, rdat, r);
      check("unmapped rd data", rdat, 32'h0000_0000);
      check("unmapped rd resp", r, RESP_SLVERR);
   endtask

   // Trim and pipe status over the register bus; a write to the status word is ignored.
   task automatic t_regmap();
      wr(OFS_TRIM, 8'h3C, r);
      check("trim wr resp", r, RESP_OKAY);
      @(negedge mclk);
      check("trim out", trim, 32'h0000_003C);
      rd(OFS_TRIM, rdat, r);
      check("trim rd", rdat, 32'h0000_003C);
      wr(OFS_PIPE, 8'hFF, r);
      check("pipe wr resp", r, RESP_OKAY);
      rd(OFS_PIPE, rdat, r);
      check("pipe status", rdat, {24'h00_0000, 6'h00, PIPE_NONE});
   endtask

   // Short frames raise the trim, long frames lower it.
   task automatic t_trim();
      host.send(1'b1, 8'h00);
      @(negedge mclk);
      check("trim long first", trim, TRIM_RST - 8'h01);
      b = trim;
      repeat (10) @(posedge mclk);
      host.send(1'b1, 8'h00);
      @(negedge mclk);
      check("trim up", trim, b + 8'h01);
      repeat (4 * FRAME_T) @(posedge mclk);
      host.send(1'b1, 8'h00);
      @(negedge mclk);
      check("trim down", trim, b);
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   // Software keeps the clock running before enabling the transceiver.
   initial
   begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      t_reset();
      t_regs();
      t_pullup();
      t_tokens();
      t_buffer();
      t_unmapped();
      t_trim();
      t_regmap();
      stop_test();
   end

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #1_000_000;
      num_errors++;
      stop_test();
   end
endmodule // ufx_top_tb
